// File: inc/dcf_pkg.sv
package dcf_pkg;

	// ----------------------------------------
	// Register map, byte addresses
	// ----------------------------------------
	localparam logic [11:0] REG_STATUS      = 12'h000;
	localparam logic [11:0] REG_EMPTY_OFF   = 12'h004;
	localparam logic [11:0] REG_FULL_OFF    = 12'h008;
	localparam logic [11:0] REG_LEVEL       = 12'h00C;

	// ----------------------------------------
	// Status field positions
	// ----------------------------------------
	localparam int ST_EMPTY_N    = 0;
	localparam int ST_FULL_N     = 1;
	localparam int ST_OUT_RDY_N  = 2;
	localparam int ST_IN_RDY_N   = 3;
	localparam int ST_AEMPTY_N   = 4;
	localparam int ST_AFULL_N    = 5;
	localparam int ST_HALF_N     = 6;
	localparam int ST_FALL_THRU  = 7;
	localparam int ST_SERIAL     = 8;
	localparam int ST_RT_BUSY    = 9;

	// ----------------------------------------
	// Reset values and default offsets
	// ----------------------------------------
	localparam int DEF_OFF_PARALLEL = 127;   // 07FH
	localparam int DEF_OFF_SERIAL   = 1023;  // 3FFH
	localparam logic RST_EMPTY_N    = 1'b0;
	localparam logic RST_FULL_N     = 1'b1;
	localparam logic RST_OUT_RDY_N  = 1'b1;
	localparam logic RST_IN_RDY_N   = 1'b0;
	localparam logic RST_AEMPTY_N   = 1'b0;
	localparam logic RST_AFULL_N    = 1'b1;
	localparam logic RST_HALF_N     = 1'b1;

	// ----------------------------------------
	// Retransmit sequencer states
	// ----------------------------------------
	typedef enum logic [1:0] {
		RT_IDLE  = 2'b01,
		RT_SETUP = 2'b10
	} dcf_rt_state_t;

endpackage : dcf_pkg

// File: logic/dcf_gray_sync.sv
// Two-stage pointer synchroniser, advancing on the far side's clock enable
module dcf_gray_sync #(
	parameter int W = 17
) (
	input  wire logic         ref_clk_i,
	input  wire logic         rst_b_i,
	input  wire logic         en_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	logic [W-1:0] stage1;

	// ----------------------------------------
	// First stage feeds only the second stage
	// ----------------------------------------
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			stage1 <= '0;
			q_o    <= '0;
		end else if (en_i) begin
			stage1 <= d_i;
			q_o    <= stage1;
		end
	end

endmodule : dcf_gray_sync

// File: logic/dcf_fifo_ctrl.sv
// Function
// R1 - master reset clears pointers, sets partial flags
// R2 - master reset latches standard or fall-through mode
// R3 - load low: offsets 127, parallel loading only
// R4 - load high: offsets 1023, serial loading only
// R5 - offset readback always allowed in parallel
// R6 - master reset async, clears output; required first
// R7 - partial reset clears pointers, keeps mode flags
// R8 - partial reset keeps offsets, method; clears output
// R9 - enables inactive before rewind request goes low
// R10 - rewind low at read edge restarts read pointer
// R11 - standard: empty low during rewind, then reads
// R12 - fall-through: ready high, first word auto-presented
// R13 - fall-through: first word out after three edges
// R14 - standard: reader requests every word
// R15 - mode pin shifts serial offsets after reset
// R16 - write enable low and not full stores word
// R17 - write enable ignored while full
// R18 - full flag low when full, two-cycle recovery
// R19 - input-ready high when full, two-cycle recovery
// R20 - write side only drives half-full low
// R21 - read side only drives half-full high
// R22 - read ignored when empty; empty two-cycle update
// R23 - flags double or triple registered per domain
// R24 - fall-through capacity counts output register
// R25 - depth parameter, derived pointer widths
// R26 - gray pointers synchronised across domains
module dcf_fifo_ctrl #(
	parameter int DEPTH = 65536,
	parameter int DW    = 9
) (
	input  wire logic          ref_clk_i,
	input  wire logic          rst_b_i,
	input  wire logic          master_reset_n_i,
	input  wire logic          partial_reset_n_i,
	input  wire logic          rewind_request_n_i,
	input  wire logic          mode_or_serial_in_i,
	input  wire logic          load_select_n_i,
	input  wire logic          serial_enable_n_i,
	input  wire logic          wr_clk_en_i,
	input  wire logic          rd_clk_en_i,
	input  wire logic          write_enable_n_i,
	input  wire logic          read_enable_n_i,
	input  wire logic [DW-1:0] data_in_i,
	output logic      [DW-1:0] data_out_o,
	output logic               empty_flag_n_o,
	output logic               output_ready_n_o,
	output logic               full_flag_n_o,
	output logic               input_ready_n_o,
	output logic               almost_empty_n_o,
	output logic               almost_full_n_o,
	output logic               half_full_n_o,
	input  wire logic          psel_i,
	input  wire logic          penable_i,
	input  wire logic          pwrite_i,
	input  wire logic [11:0]   paddr_i,
	input  wire logic [31:0]   pwdata_i,
	output logic      [31:0]   prdata_o,
	output logic               pready_o,
	output logic               pslverr_o
);

	localparam int AW = $clog2(DEPTH);                  // [R25]
	localparam int PW = AW + 1;
	localparam int OW = (AW > $clog2(dcf_pkg::DEF_OFF_SERIAL + 1)) ? AW : $clog2(dcf_pkg::DEF_OFF_SERIAL + 1);
	localparam logic [PW-1:0] FULL_CNT = PW'(DEPTH);
	localparam logic [PW-1:0] HALF_CNT = PW'(DEPTH / 2);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
		logic [PW-1:0] b;
		b[PW-1] = g[PW-1];
		for (int i = PW - 2; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction : gray2bin

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [DW-1:0]  mem [DEPTH];
	logic           ptr_rst_n;
	logic           fall_through;
	logic           serial_sel;
	logic [OW-1:0]  empty_off;
	logic [OW-1:0]  full_off;
	logic [PW-1:0]  wr_ptr;
	logic [PW-1:0]  wr_gray;
	logic [PW-1:0]  rd_ptr;
	logic [PW-1:0]  rd_gray;
	logic [PW-1:0]  wr_gray_rs;
	logic [PW-1:0]  rd_gray_ws;
	logic [PW-1:0]  wr_bin_rs;
	logic [PW-1:0]  rd_bin_ws;
	logic [PW-1:0]  wcount;
	logic [PW-1:0]  rcount;
	logic [PW-1:0]  next_wcount;
	logic [PW-1:0]  next_rcount;
	logic [PW-1:0]  next_rd_ptr;
	logic           out_valid;
	logic           next_out_valid;
	logic           wr_go;
	logic           do_fetch;
	logic           rd_empty;
	logic           rt_start;
	dcf_pkg::dcf_rt_state_t rt_state;
	logic           apb_setup;
	logic           apb_write;

	// Pointer reset: master or partial, both asynchronous
	assign ptr_rst_n = rst_b_i & master_reset_n_i & partial_reset_n_i;  // [R1] [R7]

	// ----------------------------------------
	// Mode latch and offset registers
	// ----------------------------------------
	assign apb_setup = psel_i & ~penable_i;
	assign apb_write = psel_i & penable_i & pready_o & pwrite_i;

	// Strap sampled by the clock while master reset is held; partial leaves it
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			fall_through <= 1'b0;
			serial_sel   <= 1'b0;
			empty_off    <= OW'(dcf_pkg::DEF_OFF_PARALLEL);
			full_off     <= OW'(dcf_pkg::DEF_OFF_PARALLEL);
		end else if (!master_reset_n_i) begin
			fall_through <= mode_or_serial_in_i;                            // [R2]
			serial_sel   <= load_select_n_i;
			if (load_select_n_i) begin
				empty_off <= OW'(dcf_pkg::DEF_OFF_SERIAL);                  // [R4]
				full_off  <= OW'(dcf_pkg::DEF_OFF_SERIAL);
			end else begin
				empty_off <= OW'(dcf_pkg::DEF_OFF_PARALLEL);                // [R3]
				full_off  <= OW'(dcf_pkg::DEF_OFF_PARALLEL);
			end
		end else if (serial_sel) begin
			// Serial chain: empty offset first, then full offset  [R15] [R8]
			if (wr_clk_en_i && !load_select_n_i && !serial_enable_n_i) begin
				empty_off <= {mode_or_serial_in_i, empty_off[OW-1:1]};
				full_off  <= {empty_off[0], full_off[OW-1:1]};
			end
		end else if (apb_write) begin
			// Parallel loading only when parallel method latched  [R3]
			if (paddr_i == dcf_pkg::REG_EMPTY_OFF) begin
				empty_off <= pwdata_i[OW-1:0];
			end
			if (paddr_i == dcf_pkg::REG_FULL_OFF) begin
				full_off <= pwdata_i[OW-1:0];
			end
		end
	end

	// ----------------------------------------
	// Write side
	// ----------------------------------------
	assign rd_bin_ws   = gray2bin(rd_gray_ws);
	assign wcount      = wr_ptr - rd_bin_ws;
	// Full means memory full; output register adds one in fall-through  [R24]
	assign wr_go       = ~write_enable_n_i & (wcount != FULL_CNT);     // [R16] [R17]
	assign next_wcount = wcount + PW'(wr_go);

	// Write pointer and its gray copy
	always_ff @(posedge ref_clk_i or negedge ptr_rst_n) begin
		if (!ptr_rst_n) begin
			wr_ptr  <= '0;
			wr_gray <= '0;
		end else if (wr_clk_en_i && wr_go) begin
			wr_ptr  <= wr_ptr + 1'b1;                                       // [R16]
			wr_gray <= (wr_ptr + 1'b1) ^ ((wr_ptr + 1'b1) >> 1);            // [R26]
		end
	end

	// Storage is not reset; only pointers define contents
	always_ff @(posedge ref_clk_i) begin
		if (wr_clk_en_i && wr_go) begin
			mem[wr_ptr[AW-1:0]] <= data_in_i;
		end
	end

	// Write-domain flags; frozen when write enable pulses stop  [R20]
	always_ff @(posedge ref_clk_i or negedge ptr_rst_n) begin
		if (!ptr_rst_n) begin
			full_flag_n_o   <= dcf_pkg::RST_FULL_N;                         // [R7]
			input_ready_n_o <= dcf_pkg::RST_IN_RDY_N;
			almost_full_n_o <= dcf_pkg::RST_AFULL_N;                        // [R1]
		end else if (wr_clk_en_i) begin
			if (fall_through) begin
				input_ready_n_o <= (next_wcount == FULL_CNT);               // [R19] [R23]
			end else begin
				full_flag_n_o <= (next_wcount != FULL_CNT);                 // [R18] [R23]
			end
			almost_full_n_o <= (((PW + OW)'(next_wcount) + (PW + OW)'(full_off)) < (PW + OW)'(DEPTH));
		end
	end

	// Read pointer enters write domain through two stages
	dcf_gray_sync #(
		.W (PW)
	) u_rd_to_wr (
		.ref_clk_i (ref_clk_i),
		.rst_b_i   (ptr_rst_n),
		.en_i      (wr_clk_en_i),
		.d_i       (rd_gray),
		.q_o       (rd_gray_ws)
	);                                                                      // [R26]

	// ----------------------------------------
	// Read side
	// ----------------------------------------
	assign wr_bin_rs = gray2bin(wr_gray_rs);
	assign rcount    = wr_bin_rs - rd_ptr;
	assign rd_empty  = (rcount == '0);
	assign rt_start  = ~rewind_request_n_i & (rt_state == dcf_pkg::RT_IDLE);  // [R10] [R9]

	// Fetch decision; ignored while empty or while a rewind request is taken in idle
	always_comb begin
		do_fetch = 1'b0;
		if (!rt_start && !rd_empty) begin                                   // [R22]
			if (fall_through) begin
				do_fetch = !out_valid || !read_enable_n_i;                  // [R13] [R12]
			end else begin
				do_fetch = !read_enable_n_i;                                // [R14] [R11]
			end
		end
	end

	// Next pointer and output-valid state
	always_comb begin
		next_rd_ptr    = rd_ptr;
		next_out_valid = out_valid;
		if (rt_start) begin
			next_rd_ptr    = '0;                                            // [R10]
			next_out_valid = 1'b0;
		end else if (do_fetch) begin
			next_rd_ptr    = rd_ptr + 1'b1;
			next_out_valid = 1'b1;
		end else if (fall_through && !read_enable_n_i) begin
			next_out_valid = 1'b0;
		end
	end
	assign next_rcount = wr_bin_rs - next_rd_ptr;

	// Rewind sequencer: setup lasts one read enable pulse
	always_ff @(posedge ref_clk_i or negedge ptr_rst_n) begin
		if (!ptr_rst_n) begin
			rt_state <= dcf_pkg::RT_IDLE;
		end else if (rd_clk_en_i) begin
			case (rt_state)
				dcf_pkg::RT_IDLE: begin
					if (rt_start) begin
						rt_state <= dcf_pkg::RT_SETUP;                      // [R10]
					end
				end
				dcf_pkg::RT_SETUP: begin
					rt_state <= dcf_pkg::RT_IDLE;
				end
				default: begin
					rt_state <= dcf_pkg::RT_IDLE;
				end
			endcase
		end
	end

	// Read pointer, output register and valid bit
	always_ff @(posedge ref_clk_i or negedge ptr_rst_n) begin
		if (!ptr_rst_n) begin
			rd_ptr     <= '0;
			rd_gray    <= '0;
			out_valid  <= 1'b0;
			data_out_o <= '0;                                               // [R6] [R8]
		end else if (rd_clk_en_i) begin
			rd_ptr    <= next_rd_ptr;
			rd_gray   <= next_rd_ptr ^ (next_rd_ptr >> 1);                  // [R26]
			out_valid <= next_out_valid;
			if (do_fetch) begin
				data_out_o <= mem[rd_ptr[AW-1:0]];
			end
		end
	end

	// Read-domain flags; frozen when read enable pulses stop  [R21]
	always_ff @(posedge ref_clk_i or negedge ptr_rst_n) begin
		if (!ptr_rst_n) begin
			empty_flag_n_o   <= dcf_pkg::RST_EMPTY_N;                       // [R2] [R7]
			output_ready_n_o <= dcf_pkg::RST_OUT_RDY_N;
			almost_empty_n_o <= dcf_pkg::RST_AEMPTY_N;                      // [R1]
		end else if (rd_clk_en_i) begin
			if (fall_through) begin
				output_ready_n_o <= !next_out_valid;                        // [R12] [R23]
			end else if (rt_start) begin
				empty_flag_n_o <= 1'b0;                                     // [R11]
			end else begin
				empty_flag_n_o <= (next_rcount != '0);                      // [R22] [R23]
			end
			almost_empty_n_o <= ((PW + OW)'(next_rcount) > (PW + OW)'(empty_off));
		end
	end

	// Write pointer enters read domain through two stages
	dcf_gray_sync #(
		.W (PW)
	) u_wr_to_rd (
		.ref_clk_i (ref_clk_i),
		.rst_b_i   (ptr_rst_n),
		.en_i      (rd_clk_en_i),
		.d_i       (wr_gray),
		.q_o       (wr_gray_rs)
	);                                                                      // [R26]

	// ----------------------------------------
	// Half-full: each side may move it one way only
	// ----------------------------------------
	always_ff @(posedge ref_clk_i or negedge ptr_rst_n) begin
		if (!ptr_rst_n) begin
			half_full_n_o <= dcf_pkg::RST_HALF_N;                           // [R1] [R7]
		end else if (wr_clk_en_i && (next_wcount > HALF_CNT)) begin
			half_full_n_o <= 1'b0;                                          // [R20]
		end else if (rd_clk_en_i && (next_rcount <= HALF_CNT)) begin
			half_full_n_o <= 1'b1;                                          // [R21]
		end
	end

	// ----------------------------------------
	// APB slave: one wait-free access, data prepared in setup
	// ----------------------------------------
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= '0;
		end else begin
			pready_o  <= apb_setup;
			pslverr_o <= 1'b0;
			prdata_o  <= '0;
			if (apb_setup) begin
				case (paddr_i)
					dcf_pkg::REG_STATUS: begin
						prdata_o[dcf_pkg::ST_EMPTY_N]   <= empty_flag_n_o;
						prdata_o[dcf_pkg::ST_FULL_N]    <= full_flag_n_o;
						prdata_o[dcf_pkg::ST_OUT_RDY_N] <= output_ready_n_o;
						prdata_o[dcf_pkg::ST_IN_RDY_N]  <= input_ready_n_o;
						prdata_o[dcf_pkg::ST_AEMPTY_N]  <= almost_empty_n_o;
						prdata_o[dcf_pkg::ST_AFULL_N]   <= almost_full_n_o;
						prdata_o[dcf_pkg::ST_HALF_N]    <= half_full_n_o;
						prdata_o[dcf_pkg::ST_FALL_THRU] <= fall_through;
						prdata_o[dcf_pkg::ST_SERIAL]    <= serial_sel;
						prdata_o[dcf_pkg::ST_RT_BUSY]   <= (rt_state == dcf_pkg::RT_SETUP);
					end
					dcf_pkg::REG_EMPTY_OFF: begin
						prdata_o[OW-1:0] <= empty_off;                      // [R5]
					end
					dcf_pkg::REG_FULL_OFF: begin
						prdata_o[OW-1:0] <= full_off;                       // [R5]
					end
					dcf_pkg::REG_LEVEL: begin
						prdata_o[PW-1:0] <= rcount;
					end
					default: begin
						pslverr_o <= 1'b1;                                  // Unmapped address
					end
				endcase
				if (pwrite_i && (paddr_i == dcf_pkg::REG_STATUS || paddr_i == dcf_pkg::REG_LEVEL)) begin
					pslverr_o <= 1'b1;                                      // Read-only
				end
			end
		end
	end

endmodule : dcf_fifo_ctrl

// File: sim/dcf_clk_agent.sv
// Far-side writer and reader clocks, as enable pulses on the system clock
module dcf_clk_agent (
	input  wire logic       ref_clk_i,
	input  wire logic       rst_b_i,
	input  wire logic [3:0] wr_div_i,
	input  wire logic [3:0] rd_div_i,
	output logic            wr_clk_en_o,
	output logic            rd_clk_en_o
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [3:0] wcnt;
	logic [3:0] rcnt;

	// Write clock; a larger divisor makes a slow writer
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wcnt <= 4'h0;
		end else begin
			wcnt <= (wcnt >= wr_div_i) ? 4'h0 : wcnt + 4'h1;
		end
	end
	assign wr_clk_en_o = (wcnt == 4'h0);

	// Read clock; divisors differ so the two edges drift apart
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rcnt <= 4'h0;
		end else begin
			rcnt <= (rcnt >= rd_div_i) ? 4'h0 : rcnt + 4'h1;
		end
	end
	assign rd_clk_en_o = (rcnt == 4'h0);
endmodule : dcf_clk_agent

// File: sim/dcf_fifo_ctrl_properties.sv
// Watches the controller's ports only
module dcf_chk #(
	parameter int DW = 9
) (
	input wire logic          ref_clk_i,
	input wire logic          rst_b_i,
	input wire logic          master_reset_n_i,
	input wire logic          partial_reset_n_i,
	input wire logic          rewind_request_n_i,
	input wire logic          wr_clk_en_i,
	input wire logic          rd_clk_en_i,
	input wire logic          write_enable_n_i,
	input wire logic          read_enable_n_i,
	input wire logic [DW-1:0] data_out_o,
	input wire logic          empty_flag_n_o,
	input wire logic          output_ready_n_o,
	input wire logic          full_flag_n_o,
	input wire logic          input_ready_n_o,
	input wire logic          almost_empty_n_o,
	input wire logic          almost_full_n_o,
	input wire logic          half_full_n_o,
	input wire logic          psel_i,
	input wire logic          penable_i,
	input wire logic          pwrite_i,
	input wire logic [11:0]   paddr_i,
	input wire logic          pready_o,
	input wire logic          pslverr_o
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [6:0] flg;
	logic       rs_q;
	logic       quiet;

	// ------------------------------------
	// Helpers
	// ------------------------------------
	// Flag edges caused by a FIFO reset are excluded this cycle and next
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rs_q <= 1'b0;
		end else begin
			rs_q <= master_reset_n_i & partial_reset_n_i;
		end
	end
	assign quiet = rs_q & master_reset_n_i & partial_reset_n_i;
	assign flg   = {empty_flag_n_o, full_flag_n_o, output_ready_n_o, input_ready_n_o,
		almost_empty_n_o, almost_full_n_o, half_full_n_o};

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);

	// ------------------------------------
	// Assertions
	// ------------------------------------
	a_mrst_flags: assert property (!master_reset_n_i |-> flg == 7'h33 && data_out_o == '0)
		else $error("flags or output wrong during master reset");
	a_prst_flags: assert property (!partial_reset_n_i |-> flg == 7'h33 && data_out_o == '0)
		else $error("flags or output wrong during partial reset");
	a_apb_ready: assert property (psel_i && !penable_i |=> pready_o ##1 !pready_o)
		else $error("ready not a single access-phase pulse");
	a_apb_refuse: assert property (psel_i && !penable_i && (paddr_i > 12'h00C
		|| (pwrite_i && (paddr_i == 12'h000 || paddr_i == 12'h00C))) |=> pslverr_o)
		else $error("bad access not refused");
	a_full_wclk: assert property (quiet && $changed(full_flag_n_o) |-> $past(wr_clk_en_i))
		else $error("full flag moved off a write edge");
	a_inrdy_wclk: assert property (quiet && $changed(input_ready_n_o) |-> $past(wr_clk_en_i))
		else $error("input ready moved off a write edge");
	a_empty_rclk: assert property (quiet && $changed({empty_flag_n_o, output_ready_n_o})
		|-> $past(rd_clk_en_i))
		else $error("empty or output ready moved off a read edge");
	a_half_fall: assert property (quiet && $fell(half_full_n_o) |-> $past(wr_clk_en_i))
		else $error("half full fell off a write edge");
	a_half_rise: assert property (quiet && $rose(half_full_n_o) |-> $past(rd_clk_en_i))
		else $error("half full rose off a read edge");
	a_rewind_setup: assert property (quiet && rd_clk_en_i && !rewind_request_n_i && read_enable_n_i
		&& write_enable_n_i |=> !empty_flag_n_o && output_ready_n_o)
		else $error("rewind setup not flagged");

	c_rewind: cover property (rd_clk_en_i && !rewind_request_n_i);
	c_full: cover property (!full_flag_n_o);
	c_in_full: cover property (input_ready_n_o && !output_ready_n_o);
	c_fall_out: cover property ($fell(output_ready_n_o));
endmodule : dcf_chk

bind dcf_fifo_ctrl dcf_chk #(.DW(DW)) u_chk (.ref_clk_i, .rst_b_i, .master_reset_n_i, .partial_reset_n_i,
	.rewind_request_n_i, .wr_clk_en_i, .rd_clk_en_i, .write_enable_n_i, .read_enable_n_i, .data_out_o,
	.empty_flag_n_o, .output_ready_n_o, .full_flag_n_o, .input_ready_n_o, .almost_empty_n_o,
	.almost_full_n_o, .half_full_n_o, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pready_o, .pslverr_o);

// File: sim/tb_dual_clock_fifo_control.sv
module tb_dual_clock_fifo_control;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int DEPTH = 16;
	logic        ref_clk_i, rst_b_i, mrst_n, prst_n, rw_n, mode, ld_n, we_n, re_n, wck, rck, sen_n;
	logic        psel, pen, pwr, pready, pslverr, e, ef_n, or_n, ff_n, ir_n, ae_n, af_n, hf_n;
	logic [3:0]  wdiv, rdiv;
	logic [8:0]  din, dout;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	int          n_mismatch, total_checks, n;

	// ------------------------------------
	// Clock, far side and design
	// ------------------------------------
	initial begin
		ref_clk_i = 1'b0;
		forever #2.5 ref_clk_i = ~ref_clk_i;
	end
	dcf_clk_agent u_agent (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .wr_div_i(wdiv), .rd_div_i(rdiv),
		.wr_clk_en_o(wck), .rd_clk_en_o(rck));
	// Serial offset shifting is driven from the bench
	dcf_fifo_ctrl #(.DEPTH(DEPTH)) dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .master_reset_n_i(mrst_n),
		.partial_reset_n_i(prst_n), .rewind_request_n_i(rw_n), .mode_or_serial_in_i(mode),
		.load_select_n_i(ld_n), .serial_enable_n_i(sen_n), .wr_clk_en_i(wck), .rd_clk_en_i(rck),
		.write_enable_n_i(we_n), .read_enable_n_i(re_n), .data_in_i(din), .data_out_o(dout),
		.empty_flag_n_o(ef_n), .output_ready_n_o(or_n), .full_flag_n_o(ff_n), .input_ready_n_o(ir_n),
		.almost_empty_n_o(ae_n), .almost_full_n_o(af_n), .half_full_n_o(hf_n), .psel_i(psel),
		.penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr));

	// ------------------------------------
	// Shared tasks
	// ------------------------------------
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %0h seen %0h", what, exp, got);
		end
	endtask : check

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk_i);
		pen <= 1'b1;
		do begin
			@(posedge ref_clk_i);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb

	task automatic wait_pulse(input bit rd);
		int i;
		i = 0;
		do begin
			@(posedge ref_clk_i);
			i++;
		end while ((rd ? rck : wck) !== 1'b1 && i < 64);
	endtask : wait_pulse

	task automatic push(input logic [8:0] d);
		@(posedge ref_clk_i);
		din <= d;
		we_n <= 1'b0;
		wait_pulse(1'b0);
		we_n <= 1'b1;
	endtask : push

	// Standard read; waits out the empty flag first
	task automatic pop(input logic [8:0] exp);
		for (int i = 0; i < 200 && ef_n !== 1'b1; i++) @(posedge ref_clk_i);
		@(posedge ref_clk_i);
		re_n <= 1'b0;
		wait_pulse(1'b1);
		re_n <= 1'b1;
		#1;
		check("data_out", 32'(exp), 32'(dout));
	endtask : pop

	// Fall-through read: word is already shown, the read moves on
	task automatic ft_pop(input logic [8:0] exp);
		#1; // Let the previous read's output settle
		for (int i = 0; i < 200 && or_n !== 1'b0; i++) @(posedge ref_clk_i);
		check("ft data_out", 32'(exp), 32'(dout));
		@(posedge ref_clk_i);
		re_n <= 1'b0;
		wait_pulse(1'b1);
		re_n <= 1'b1;
	endtask : ft_pop

	// ------------------------------------
	// Scenarios
	// ------------------------------------
	task automatic t_reset;
		check("flags", 32'h33, 32'({ef_n, ff_n, or_n, ir_n, ae_n, af_n, hf_n}));
		check("data_out", 32'h0, 32'(dout));
		mrst_n <= 1'b1;
		ld_n <= 1'b1;
		@(posedge ref_clk_i);
		apb(1'b0, dcf_pkg::REG_STATUS, 32'h0);
		check("mode bits", 32'h0, 32'(q[8:7]));
		apb(1'b0, dcf_pkg::REG_FULL_OFF, 32'h0);
		check("full off", 32'h7F, q);
		apb(1'b1, dcf_pkg::REG_EMPTY_OFF, 32'h5);
		apb(1'b0, dcf_pkg::REG_EMPTY_OFF, 32'h0);
		check("empty off", 32'h5, q);
		apb(1'b0, 12'h010, 32'h0);
		check("unmapped err", 32'h1, 32'(e));
		apb(1'b1, dcf_pkg::REG_STATUS, 32'h0);
		check("ro err", 32'h1, 32'(e));
	endtask : t_reset

	// Overfill with a slow reader, then drain in order
	task automatic t_std_fill;
		for (int i = 0; i < DEPTH + 2; i++) push(9'(9'h150 + i));
		check("full", 32'h0, 32'(ff_n));
		check("half", 32'h0, 32'(hf_n));
		pop(9'h150);
		for (int i = 0; i < 40 && ff_n !== 1'b1; i++) @(posedge ref_clk_i);
		check("full back", 32'h1, 32'(ff_n));
		for (int i = 1; i < DEPTH; i++) pop(9'(9'h150 + i));
		for (int i = 0; i < 40 && ef_n !== 1'b0; i++) @(posedge ref_clk_i);
		@(posedge ref_clk_i);
		re_n <= 1'b0;
		wait_pulse(1'b1);
		re_n <= 1'b1;
		#1;
		check("empty read", 32'(9'h15F), 32'(dout));
		check("half back", 32'h1, 32'(hf_n));
	endtask : t_std_fill

	task automatic t_prs_rewind;
		@(posedge ref_clk_i);
		prst_n <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		check("prs flags", 32'h33, 32'({ef_n, ff_n, or_n, ir_n, ae_n, af_n, hf_n}));
		check("prs data_out", 32'h0, 32'(dout));
		prst_n <= 1'b1;
		apb(1'b0, dcf_pkg::REG_EMPTY_OFF, 32'h0);
		check("kept off", 32'h5, q);
		for (int i = 0; i < 3; i++) push(9'(9'h0C1 + i));
		for (int i = 0; i < 2; i++) pop(9'(9'h0C1 + i));
		@(posedge ref_clk_i);
		rw_n <= 1'b0;
		wait_pulse(1'b1);
		rw_n <= 1'b1;
		#1;
		check("rt empty", 32'h0, 32'(ef_n));
		for (int i = 0; i < 3; i++) pop(9'(9'h0C1 + i));
	endtask : t_prs_rewind

	task automatic t_fall_through;
		@(posedge ref_clk_i);
		mrst_n <= 1'b0;
		mode <= 1'b1;
		ld_n <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		mrst_n <= 1'b1;
		mode <= 1'b0;
		apb(1'b0, dcf_pkg::REG_STATUS, 32'h0);
		check("ft bits", 32'h3, 32'(q[8:7]));
		apb(1'b1, dcf_pkg::REG_EMPTY_OFF, 32'h5);
		apb(1'b0, dcf_pkg::REG_EMPTY_OFF, 32'h0);
		check("serial off", 32'h3FF, q);
		// Zeros on the serial input, enough pulses to flush both offsets
		@(posedge ref_clk_i);
		{ld_n, sen_n} <= 2'b00;
		repeat (64) @(posedge ref_clk_i);
		{ld_n, sen_n} <= 2'b11;
		apb(1'b0, dcf_pkg::REG_FULL_OFF, 32'h0);
		check("serial shift", 32'h0, q);
		push(9'h1E0);
		n = 0;
		for (int i = 0; i < 64 && or_n !== 1'b0; i++) begin
			@(posedge ref_clk_i);
			if (rck) n++;
			#1;
		end
		check("fall edges", 32'h3, 32'(n));
		for (int i = 0; i < DEPTH; i++) push(9'(9'h100 + i));
		for (int i = 0; i < 40 && ir_n !== 1'b1; i++) @(posedge ref_clk_i);
		check("in full", 32'h1, 32'(ir_n));
		ft_pop(9'h1E0);
		for (int i = 0; i < 40 && ir_n !== 1'b0; i++) @(posedge ref_clk_i);
		check("in ready back", 32'h0, 32'(ir_n));
		for (int i = 0; i < DEPTH; i++) ft_pop(9'(9'h100 + i));
		#1;
		check("ft empty", 32'h1, 32'(or_n));
	endtask : t_fall_through

	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : results

	// ------------------------------------
	// Main sequence and watchdog
	// ------------------------------------
	initial begin
		{rst_b_i, mrst_n, mode, ld_n, psel, pen, pwr} = 7'h00;
		{prst_n, rw_n, we_n, re_n, sen_n} = 5'h1F;
		{din, paddr, pwdata, wdiv, rdiv} = '0;
		wdiv = 4'h1;
		rdiv = 4'h4;
		repeat (16) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i); // Master reset outlives power-up reset
		t_reset();
		t_std_fill();
		rdiv <= 4'h2;
		t_prs_rewind();
		t_fall_through();
		results();
	end

	// Run needs well under a thousand cycles; this is far beyond it
	initial begin
		#400000;
		n_mismatch++;
		results();
	end
endmodule : tb_dual_clock_fifo_control
